/* dv/pchr_chip_tb.sv */
`default_nettype none
// self-checking bench for the readout chip
module pchr_chip_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pchr_pkg::*;
   logic clk, rst, xclk, acc, acc_req, wr, rd, vld;
   logic rd_d = 1'b0;          // a read is owed its data this cycle
   logic xd = 1'b0;            // crossing clock one cycle ago
   logic [7:0] xcnt = 8'h00;   // crossing edges seen since reset
   logic [7:0] stp, trig, cur; // stamp owed, trigger count, chip count
   logic [3:0] addr;
   logic [31:0] wdata, rdata, seed = 32'h40C4;
   logic [17:0][159:0] hit;
   logic [17:0][159:0][2:0] adc;
   pchr_bus_word_t word;
   logic [31:0] rq[$]; // read data still owed, oldest first
   logic [26:0] wq[$]; // marker, col, row, adc, code, stamp owed
   int n_fail = 0, tests_run = 0;
   pchr_daq daq (.clk_in(clk), .run_in(!rst), .acc_in(acc_req),
      .xclk_out(xclk), .acc_out(acc));
   pchr_chip dut (.sys_clk_in(clk), .rst_in(rst), .xclk_in(xclk),
      .trigger_accept_in(acc), .trig_count_in(trig),
      .disc_hit_in(hit), .adc_in(adc), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .rd_valid_out(vld), .rd_word_out(word),
      .current_crossing_count_out(cur));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   task automatic cmp(input string n, input logic [31:0] e, s);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // strobes stay up so accesses can run back to back
   task automatic bus(input logic w, logic [3:0] a, logic [31:0] d);
      if (!w) rq.push_back(d);
      {wr, rd, addr, wdata} <= {w, !w, a, d};
      @(posedge clk);
   endtask
   // one pixel hit with random comparator levels, owed at stamp stp
   task automatic px(input int c, r, input logic keep);
      seed = xs(seed);
      {hit[c][r], adc[c][r]} <= {1'b1, seed[2:0]};
      if (keep) wq.push_back({1'b1, 5'(c), 8'(r), seed[2:0],
         2'($countones(seed[2:0])), stp});
   endtask
   // wait, bounded, for a crossing edge; hits placed now carry its count
   task automatic align;
      for (int k = 0; k < 16 && !(xclk && !xd); k++) @(posedge clk);
      cmp("crossing edge", 32'h1, 32'(xclk && !xd));
      cmp("crossing count", 32'(xcnt), 32'(cur));
      stp = xcnt + 8'h01;
   endtask
   // external trigger round; a zero mask resets the set at the next edge
   task automatic ext(input logic [7:0] m, input logic keep);
      bus(1, PCHR_REG_MASK, 32'(m));
      {wr, rd} <= 2'b00;
      align;
      px(5, keep ? 47 : 7, keep);
      repeat (4) @(posedge clk);
      hit <= '0;
      repeat (40) @(posedge clk);
      trig <= stp;
      // trigger count settles before the falling edge
      repeat (6) @(posedge clk);
      acc_req <= 1'b0;
      repeat (60) @(posedge clk);
      acc_req <= 1'b1;
      repeat (10) @(posedge clk);
   endtask
   // next note owed, or a value that no result can take
   function automatic logic [31:0] owed(input logic w);
      if (w) return wq.size() != 0 ? 32'(wq.pop_front()) : 32'hFFFFFFFF;
      return rq.size() != 0 ? rq.pop_front() : 32'hFFFFFFFF;
   endfunction
   // oldest note per result, crossing edges counted alongside
   always @(posedge clk) begin
      if (rd_d) cmp("reg read", owed(1'b0), rdata);
      if (vld === 1'b1) cmp("word", owed(1'b1), {6'h1, word});
      rd_d <= rd;
      xd <= xclk;
      if (xclk && !xd) xcnt <= xcnt + 8'h01;
   end
   initial begin
      rst = 1'b1;
      {acc_req, wr, rd, addr, wdata, trig} = '0;
      {hit, adc} = '0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      bus(0, PCHR_REG_MASK, 32'hFF);
      bus(0, PCHR_REG_STAT, 32'hFE00);
      bus(1, PCHR_REG_MASK, 32'h5A);
      bus(0, PCHR_REG_MASK, 32'h5A);
      bus(0, 4'hC, 32'h0);
      bus(1, PCHR_REG_MASK, 32'hFF);
      {wr, rd} <= 2'b00;
      // first round throttled: its hits must never come out
      for (int i = 0; i < 5 && wq.size() == 0; i++) begin
         acc_req <= (i != 0);
         repeat (20) @(posedge clk);
         align;
         px(i * 4, i, i != 0);
         px(i * 4, 159 - i, i != 0);
         px(17, 60 + seed[4:0], i != 0);
         repeat (4) @(posedge clk);
         hit <= '0;
         repeat (150) @(posedge clk);
         cmp("stream drain", 32'h0, 32'(wq.size()));
      end
      bus(1, PCHR_REG_CTRL, 32'h1);
      ext(8'h00, 1'b0);
      ext(8'hFF, 1'b1);
      cmp("trigger drain", 32'h0, 32'(wq.size()));
      end_sim;
   end
endmodule
`default_nettype wire

/* dv/pchr_daq.sv */
`default_nettype none
// far side: crossing clock and throttle level
module pchr_daq (
   input  wire logic clk_in,
   input  wire logic run_in,
   input  wire logic acc_in,
   output logic      xclk_out,
   output logic      acc_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] div_r = 3'h0; // eight master cycles a crossing
   // crossing clock stands low while the chip is held in reset
   always @(posedge clk_in) div_r <= run_in ? div_r + 3'h1 : 3'h0;
   assign xclk_out = div_r[2];
   assign acc_out = acc_in;
endmodule
`default_nettype wire

/* rtl/pchr_chip.sv */
// Our own choices: the register offsets and the plain strobed port.
`default_nettype none
// column readout chip: column ends, counters, readout control
module pchr_chip import pchr_pkg::*; #(
   parameter int COLS = PCHR_COLS,
   parameter int ROWS = PCHR_ROWS,
   parameter int TSW  = PCHR_TSW
)(
   // clock and reset
   input  wire logic                           sys_clk_in,
   input  wire logic                           rst_in,
   // crossing clock and trigger pins
   input  wire logic                           xclk_in,
   input  wire logic                           trigger_accept_in,
   input  wire logic [TSW-1:0]                 trig_count_in,
   // pixel discriminators and comparators
   input  wire logic [COLS-1:0][ROWS-1:0]      disc_hit_in,
   input  wire logic [COLS-1:0][ROWS-1:0][2:0] adc_in,
   // register port
   input  wire logic [3:0]                     reg_addr_in,
   input  wire logic [31:0]                    reg_wdata_in,
   input  wire logic                           reg_wr_in,
   input  wire logic                           reg_rd_in,
   output logic      [31:0]                    reg_rdata_out,
   // readout stream
   output logic                                rd_valid_out,
   output pchr_bus_word_t                      rd_word_out,
   output logic [TSW-1:0]                      current_crossing_count_out
);
   // the state struct is sized by the package
   if (COLS != PCHR_COLS || ROWS != PCHR_ROWS ||
       TSW != PCHR_TSW || COLS > 32) begin : g_bad
      $error("pchr_chip: geometry must match the package");
   end

   pchr_chip_st_t st_r, st_nxt;  // whole chip state

   // synchronised pin levels
   logic                        xclk_s;   // crossing clock level
   logic                        acc_s;    // trigger accept level
   logic [TSW-1:0]              trig_s;   // external count
   logic [COLS-1:0][ROWS-1:0]   hit_s;    // discriminators
   logic [COLS-1:0][ROWS-1:0][2:0] adc_s; // comparators

   // crossing and trigger events in the master domain
   logic tick;       // rising crossing clock edge
   logic trig_fall;  // falling trigger accept edge
   logic accept;     // pixels may take hits
   logic [TSW-1:0] requested_crossing_count;

   // per-column command and token signals
   logic [COLS-1:0][PCHR_SETS-1:0] outm;  // output commands
   logic [COLS-1:0][PCHR_SETS-1:0] rstm;  // reset commands
   logic [COLS-1:0][PCHR_SETS-1:0] inen;  // input commands
   logic [COLS-1:0] column_token_entry;   // token into column
   logic [COLS-1:0] column_token_exit;    // token out of top
   logic [COLS:0]   column_grant;         // grant chain
   logic [COLS-1:0] column_hit_flag;      // wired-or hit flag
   logic [COLS-1:0] readout_request_flag; // wired-or request
   pchr_pix_word_t  pw [COLS];            // column words
   logic [COLS-1:0] wvalid;               // word valid per column
   logic any_match;                       // some set matches
   logic last_grant;                      // last column let go

   // pin synchronisers, two flops before any logic
   pchr_sync #(.W(1)) u_sync_xclk (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .d_in       (xclk_in),
      .q_out      (xclk_s)
   );
   pchr_sync #(.W(1)) u_sync_acc (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .d_in       (trigger_accept_in),
      .q_out      (acc_s)
   );
   pchr_sync #(.W(TSW)) u_sync_trig (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .d_in       (trig_count_in),
      .q_out      (trig_s)
   );
   pchr_sync #(.W(COLS*ROWS)) u_sync_hit (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .d_in       (disc_hit_in),
      .q_out      (hit_s)
   );
   pchr_sync #(.W(COLS*ROWS*3)) u_sync_adc (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .d_in       (adc_in),
      .q_out      (adc_s)
   );

   // edges of synchronised levels
   assign tick = xclk_s && !st_r.xclk_d;
   assign trig_fall = !acc_s && st_r.acc_d;
   // in continuous mode the accept pin throttles hits
   assign accept = st_r.mode || acc_s;
   // requested count source follows the readout mode
   assign requested_crossing_count =
      st_r.mode ? st_r.ext : st_r.rd;

   // one pixel column per column end
   for (genvar c = 0; c < COLS; c++) begin : g_col
      pchr_pixcol #(.ROWS(ROWS)) u_pix (
         .sys_clk_in               (sys_clk_in),
         .rst_in                   (rst_in),
         .hit_in                   (hit_s[c]),
         .adc_in                   (adc_s[c]),
         .accept_in                (accept),
         .in_valid_in              (|inen[c]),
         .in_set_in                (st_r.ptr[c]),
         .out_cmd_in               (outm[c]),
         .rst_cmd_in               (rstm[c]),
         .column_token_entry_in    (column_token_entry[c]),
         .column_grant_in          (column_grant[c]),
         .column_hit_flag_out      (column_hit_flag[c]),
         .readout_request_flag_out (readout_request_flag[c]),
         .column_token_exit_out    (column_token_exit[c]),
         .word_out                 (pw[c])
      );
      assign wvalid[c] = pw[c].v;
   end

   // column end comparators and grant chain
   always_comb begin
      for (int c = 0; c < COLS; c++) begin
         for (int s = 0; s < PCHR_SETS; s++) begin
            // requested count match issues output
            outm[c][s] = st_r.occ[c][s] &&
               st_r.ts[c][s] == requested_crossing_count;
            // masked current count match issues reset
            rstm[c][s] = st_r.occ[c][s] && tick && !outm[c][s] &&
               ((st_r.cur ^ st_r.ts[c][s]) & st_r.mask) == '0;
            // only the pointed, empty set issues input
            inen[c][s] = st_r.ptr[c] == 2'(s) &&
               !st_r.occ[c][s];
         end
         // token enters early, before the grant arrives
         column_token_entry[c] = |outm[c];
      end
      // chip grant starts the chain at column zero
      column_grant[0] = st_r.phase == PH_READ;
      for (int c = 0; c < COLS; c++) begin
         // pass on as soon as the token leaves the top
         column_grant[c+1] = column_grant[c] &&
            (!column_token_entry[c] || column_token_exit[c]);
      end
      any_match = |column_token_entry;
      last_grant = column_grant[COLS];
   end

   // next state of the whole chip
   always_comb begin
      st_nxt = st_r;
      st_nxt.xclk_d = xclk_s;
      st_nxt.acc_d = acc_s;
      st_nxt.rdata = '0;
      st_nxt.ovalid = 1'b0;
      st_nxt.oword = '0;

      // register writes; offsets outside the map are ignored
      if (reg_wr_in) begin
         if (reg_addr_in == PCHR_REG_CTRL) begin
            st_nxt.mode = reg_wdata_in[0];
         end else if (reg_addr_in == PCHR_REG_MASK) begin
            st_nxt.mask = reg_wdata_in[TSW-1:0];
         end
      end
      // register reads; unmapped offsets read zero
      if (reg_rd_in) begin
         if (reg_addr_in == PCHR_REG_CTRL) begin
            st_nxt.rdata = 32'(st_r.mode);
         end else if (reg_addr_in == PCHR_REG_MASK) begin
            st_nxt.rdata = 32'(st_r.mask);
         end else if (reg_addr_in == PCHR_REG_STAT) begin
            st_nxt.rdata = 32'({st_r.phase, st_r.rd, st_r.cur});
         end
      end

      // external count is presented on the falling edge
      if (trig_fall) st_nxt.ext = trig_s;

      // crossing counter, wraps at its width
      if (tick) st_nxt.cur = st_r.cur + TSW'(1);

      for (int c = 0; c < COLS; c++) begin
         // hit flag is held until the crossing edge
         if (tick) st_nxt.hseen[c] = 1'b0;
         else if (column_hit_flag[c]) st_nxt.hseen[c] = 1'b1;
         // a set frees on reset or once its column let go
         for (int s = 0; s < PCHR_SETS; s++) begin
            if (rstm[c][s] ||
                (outm[c][s] && column_grant[c+1])) begin
               st_nxt.occ[c][s] = 1'b0;
            end
         end
         // the input set latches the count and goes idle
         if (tick && (st_r.hseen[c] || column_hit_flag[c]) &&
             !st_r.occ[c][st_r.ptr[c]]) begin
            st_nxt.occ[c][st_r.ptr[c]] = 1'b1;
            st_nxt.ts[c][st_r.ptr[c]] = st_r.cur;
         end
         // encoder moves input duty to the next free set
         if (st_nxt.occ[c][st_r.ptr[c]]) begin
            st_nxt.ptr[c] =
               pchr_next_free(st_nxt.occ[c], st_r.ptr[c]);
         end
      end

      // readout controller
      case (st_r.phase)
         PH_SEEK: begin
            // freeze and grant on a match, else trail the count in continuous mode
            if (any_match) begin
               st_nxt.phase = PH_READ;
            end else if (!st_r.mode && tick) begin
               st_nxt.rd = st_r.rd + TSW'(1);
            end
         end
         PH_READ: begin
            // the last column let go: bus passes on at the edge
            if (last_grant) begin
               st_nxt.phase = st_r.mode ? PH_SEEK : PH_FAST;
            end
         end
         PH_FAST: begin
            // step each master cycle until match or lag
            if (any_match) begin
               st_nxt.phase = PH_READ;
            end else if (st_r.rd == st_r.cur - PCHR_LAG) begin
               st_nxt.phase = PH_SEEK;
               if (tick) st_nxt.rd = st_r.rd + TSW'(1);
            end else begin
               st_nxt.rd = st_r.rd + TSW'(1);
            end
         end
         default: begin
            st_nxt.phase = PH_SEEK;
         end
      endcase

      // one column at most drives a word each cycle
      for (int c = 0; c < COLS; c++) begin
         if (pw[c].v) begin
            st_nxt.ovalid = 1'b1;
            st_nxt.oword.col = PCHR_COLW'(c);
            st_nxt.oword.row = pw[c].row;
            st_nxt.oword.adc = pw[c].adc;
            st_nxt.oword.code = pchr_encode(pw[c].adc);
            st_nxt.oword.stamp = requested_crossing_count;
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         st_r <= '0;
         st_r.phase <= PH_SEEK;
         st_r.rd <= PCHR_RD_RST;
         st_r.mask <= PCHR_MASK_RST;
         st_r.mode <= PCHR_MODE_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // outputs, all from flip-flops
   assign reg_rdata_out = st_r.rdata;
   assign rd_valid_out = st_r.ovalid;
   assign rd_word_out = st_r.oword;
   assign current_crossing_count_out = st_r.cur;

   // checks
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   for (genvar c = 0; c < COLS; c++) begin : g_chk
      a_one_input: assert property ($onehot0(inen[c]))
         else $error("two sets issue input in one column");
      a_hit_latch: assert property (
         tick && (st_r.hseen[c] || column_hit_flag[c]) &&
         !st_r.occ[c][st_r.ptr[c]]
         |=> st_r.occ[c][$past(st_r.ptr[c])] &&
             st_r.ts[c][$past(st_r.ptr[c])] == $past(st_r.cur))
         else $error("hit crossing not latched");
   end

   a_cur_step: assert property (
      tick |=> st_r.cur == $past(st_r.cur) + TSW'(1))
      else $error("crossing count did not step");
   a_read_freeze: assert property (
      st_r.phase == PH_READ && !last_grant |=> $stable(st_r.rd))
      else $error("readout count moved during readout");
   a_grant_start: assert property (
      st_r.phase == PH_SEEK && any_match
      |=> st_r.phase == PH_READ && column_grant[0])
      else $error("grant not issued after match");
   a_fast_step: assert property (
      st_r.phase == PH_FAST && !any_match &&
      st_r.rd != st_r.cur - PCHR_LAG
      |=> st_r.rd == $past(st_r.rd) + TSW'(1))
      else $error("fast stepping stalled");
   a_bus_pass: assert property (
      st_r.phase == PH_READ && last_grant |=> st_r.phase != PH_READ)
      else $error("bus not released after last column");
   a_one_word: assert property ($onehot0(wvalid))
      else $error("two columns drive the bus");
   a_throttle: assert property (
      !st_r.mode && !acc_s |-> column_hit_flag == '0)
      else $error("hit taken while throttled");
   a_ext_load: assert property (
      trig_fall |=> st_r.ext == $past(trig_s))
      else $error("external count not presented");
   a_word_out: assert property (
      |wvalid |=> rd_valid_out)
      else $error("column word not forwarded");

   c_read_done: cover property (
      st_r.phase == PH_SEEK && any_match ##[1:200] last_grant);
   c_burst: cover property (rd_valid_out [*3]);
   c_ext_trig: cover property (st_r.mode && trig_fall);
   c_reset_cmd: cover property (|rstm);
endmodule
`default_nettype wire

/* rtl/pchr_pixcol.sv */
`default_nettype none
// one column of pixel command interpreters and token chain
module pchr_pixcol import pchr_pkg::*; #(
   parameter int ROWS = PCHR_ROWS
)(
   // clock and reset
   input  wire logic                          sys_clk_in,
   input  wire logic                          rst_in,
   // synchronised discriminator and comparator levels
   input  wire logic [ROWS-1:0]               hit_in,
   input  wire logic [ROWS-1:0][PCHR_ADCW-1:0] adc_in,
   // commands from the column end
   input  wire logic                          accept_in,
   input  wire logic                          in_valid_in,
   input  wire logic [1:0]                    in_set_in,
   input  wire logic [PCHR_SETS-1:0]          out_cmd_in,
   input  wire logic [PCHR_SETS-1:0]          rst_cmd_in,
   input  wire logic                          column_token_entry_in,
   input  wire logic                          column_grant_in,
   // flags and data back to the column end
   output logic                               column_hit_flag_out,
   output logic                               readout_request_flag_out,
   output logic                               column_token_exit_out,
   output pchr_pix_word_t                     word_out
);
   if (ROWS != PCHR_ROWS || ROWS > 256) begin : g_bad
      $error("pchr_pixcol: row count does not fit state");
   end
   pchr_pix_st_t st_r, st_nxt;  // whole column state
   logic [PCHR_ROWW-1:0] sel;   // lowest requesting row
   logic found;                 // some row requests the bus
   // interpreters, token ripple and readout
   always_comb begin
      st_nxt = st_r;
      st_nxt.word = '0;
      column_hit_flag_out = 1'b0;
      found = 1'b0;
      sel = '0;
      for (int r = 0; r < ROWS; r++) begin
         if (!st_r.bound[r]) begin
            // unbound pixels watch whichever set inputs
            if (hit_in[r] && accept_in && in_valid_in) begin
               st_nxt.bound[r] = 1'b1;
               st_nxt.set[r] = in_set_in;
               st_nxt.adc[r] = adc_in[r];
               column_hit_flag_out = 1'b1;
            end // otherwise the hit is dropped
         end else begin
            // bound pixels listen to their own set only
            if (out_cmd_in[st_r.set[r]]) st_nxt.req[r] = 1'b1;
            if (rst_cmd_in[st_r.set[r]]) begin
               st_nxt.bound[r] = 1'b0;
               st_nxt.req[r] = 1'b0;
            end
         end
      end
      // token ripples from the bottom past idle pixels
      for (int r = 0; r < ROWS; r++) begin
         if (st_r.req[r] && !found) begin
            found = 1'b1;
            sel = PCHR_ROWW'(r);
         end
      end
      column_token_exit_out = column_token_entry_in && !found;
      // token holder drives one word and clears itself
      if (column_token_entry_in && column_grant_in && found) begin
         st_nxt.word = {1'b1, sel, st_r.adc[sel]};
         st_nxt.bound[sel] = 1'b0;
         st_nxt.req[sel] = 1'b0;
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) st_r <= '0;
      else st_r <= st_nxt;
   end
   // request flag is low while the last pixel is driven
   assign readout_request_flag_out = |st_r.req;
   assign word_out = st_r.word;
endmodule
`default_nettype wire

/* rtl/pchr_pkg.sv */
`default_nettype none
package pchr_pkg;
   // array geometry and field widths
   localparam int PCHR_COLS = 18;
   localparam int PCHR_ROWS = 160;
   localparam int PCHR_SETS = 4;
   localparam int PCHR_TSW  = 8;
   localparam int PCHR_ROWW = 8;
   localparam int PCHR_ADCW = 3;
   localparam int PCHR_COLW = 5;
   // readout counter lag and its reset value
   localparam logic [PCHR_TSW-1:0] PCHR_LAG    = 8'h02;
   localparam logic [PCHR_TSW-1:0] PCHR_RD_RST = 8'hFE;
   // register offsets and reset values
   localparam logic [3:0] PCHR_REG_CTRL = 4'h0;
   localparam logic [3:0] PCHR_REG_MASK = 4'h4;
   localparam logic [3:0] PCHR_REG_STAT = 4'h8;
   localparam logic [PCHR_TSW-1:0] PCHR_MASK_RST = 8'hFF;
   localparam logic PCHR_MODE_RST = 1'b0;
   // chip readout phases, gray along seek, read, fast
   typedef enum logic [1:0] {
      PH_SEEK = 2'b00,
      PH_READ = 2'b01,
      PH_FAST = 2'b11
   } pchr_phase_t;
   // word a pixel column hands to its column end
   typedef struct packed {
      logic                v;
      logic [PCHR_ROWW-1:0] row;
      logic [PCHR_ADCW-1:0] adc;
   } pchr_pix_word_t;
   // word on the chip output
   typedef struct packed {
      logic [PCHR_COLW-1:0] col;
      logic [PCHR_ROWW-1:0] row;
      logic [PCHR_ADCW-1:0] adc;
      logic [1:0]           code;
      logic [PCHR_TSW-1:0]  stamp;
   } pchr_bus_word_t;
   // state of one pixel column
   typedef struct packed {
      logic [PCHR_ROWS-1:0]                bound;
      logic [PCHR_ROWS-1:0]                req;
      logic [PCHR_ROWS-1:0][1:0]           set;
      logic [PCHR_ROWS-1:0][PCHR_ADCW-1:0] adc;
      pchr_pix_word_t                      word;
   } pchr_pix_st_t;
   // state of the chip and column ends
   typedef struct packed {
      pchr_phase_t                                    phase;
      logic [PCHR_TSW-1:0]                            cur;
      logic [PCHR_TSW-1:0]                            rd;
      logic [PCHR_TSW-1:0]                            ext;
      logic                                           mode;
      logic [PCHR_TSW-1:0]                            mask;
      logic [PCHR_COLS-1:0][PCHR_SETS-1:0]            occ;
      logic [PCHR_COLS-1:0][PCHR_SETS-1:0][PCHR_TSW-1:0] ts;
      logic [PCHR_COLS-1:0][1:0]                      ptr;
      logic [PCHR_COLS-1:0]                           hseen;
      logic                                           xclk_d;
      logic                                           acc_d;
      logic                                           ovalid;
      pchr_bus_word_t                                 oword;
      logic [31:0]                                    rdata;
   } pchr_chip_st_t;
   // three comparator levels to a two-bit code
   function automatic logic [1:0] pchr_encode(input logic [2:0] a);
      return 2'(a[0]) + 2'(a[1]) + 2'(a[2]);
   endfunction
   // next free set after ptr, else ptr itself
   function automatic logic [1:0] pchr_next_free(
      input logic [3:0] occ, input logic [1:0] ptr);
      logic [1:0] idx;
      pchr_next_free = ptr;
      for (int i = 3; i >= 1; i--) begin
         idx = ptr + 2'(i);
         if (!occ[idx]) pchr_next_free = idx;
      end
   endfunction
endpackage
`default_nettype wire

/* rtl/pchr_sync.sv */
`default_nettype none
// two-stage synchroniser for pin levels
module pchr_sync #(
   parameter int W = 1
)(
   // clock and reset
   input  wire logic         sys_clk_in,
   input  wire logic         rst_in,
   // asynchronous level in, synchronised out
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   if (W < 1) begin : g_bad
      $error("pchr_sync: width must be at least one");
   end
   logic [1:0][W-1:0] st_r;   // stage 0 feeds only stage 1
   logic [1:0][W-1:0] st_nxt;
   // shift chain
   always_comb begin
      st_nxt[0] = d_in;
      st_nxt[1] = st_r[0];
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) st_r <= '0;
      else st_r <= st_nxt;
   end
   assign q_out = st_r[1];
endmodule
`default_nettype wire
